// ---- hw/swic_ctrl.sv ----
// Purpose: interrupt flags, standby modes and wake sequencing
// Assumes: single clock; pins pass two flip-flops; apb slave, 0 waits
// Notes:   oscillator stop shown as osc_stop output; clock gating outside
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module swic_ctrl
  import swic_pkg::*;
#(
  parameter int RST_TICKS = SWIC_RST_TICKS,
  parameter int RST_DIV   = SWIC_RST_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_int_pin,
  input  wire logic        standby_release_pin_n,
  input  wire logic        timer0_match,
  input  wire logic        timer1_match,
  input  wire logic        interval_timer_ovf,
  input  wire logic        serial_done,
  input  wire logic        timer0_pin_clock,
  input  wire logic        serial_ext_clock,
  input  wire logic        irq_enter,
  output logic             cpu_clk_gate,
  output logic             osc_stop,
  output logic             timer0_hold,
  output logic             timer1_clear,
  output logic             interval_timer_hold,
  output logic             serial_hold,
  output logic             converter_clear,
  output logic             pins_force_input,
  output logic             soft_reset,
  output logic             cpu_run,
  output logic             restart_valid,
  output logic      [15:0] restart_addr,
  output logic             irq_take,
  output logic      [15:0] irq_vector
);
  initial begin
    if (RST_TICKS < 1 || RST_DIV < 1) $error("swic_ctrl: bad wait");
  end

  localparam logic [23:0] RST_WAIT = 24'(RST_TICKS * RST_DIV);

  // returns highest-priority pending index, pin first
  function automatic logic [2:0] swic_pick(input logic [4:0] p);
    logic [2:0] r;
    r = 3'd0;
    for (int i = SWIC_NSRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // two-flop synchronisers for pin inputs
  logic [1:0] int_s;
  logic [1:0] rls_s;
  logic       int_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_s <= 2'h0;
      rls_s <= 2'h3;
      int_d <= 1'b0;
    end else begin
      int_s <= {int_s[0], ext_int_pin};
      rls_s <= {rls_s[0], standby_release_pin_n};
      int_d <= int_s[1];
    end
  end
  logic rls_low;
  logic int_edge;
  assign rls_low = ~rls_s[1];

  logic [4:0]  source_request_flags;
  logic [4:0]  source_enable_flags;
  logic [1:0]  edge_sel;
  logic        global_accept_flag;
  logic [3:0]  op;
  logic [7:0]  tm1_n;
  logic [1:0]  tm1_m;
  logic [23:0] wcnt;
  logic [15:0] ret_addr;
  logic        ret_valid;
  swic_state_e state;

  logic [4:0]  next_req;
  logic [4:0]  next_en;
  logic [1:0]  next_edge;
  logic        next_accept;
  logic [3:0]  next_op;
  logic [7:0]  next_tm1_n;
  logic [1:0]  next_tm1_m;
  logic [23:0] next_wcnt;
  logic [15:0] next_ret_addr;
  logic        next_ret_valid;
  swic_state_e next_state;

  logic        wr;
  logic        rd;
  logic [2:0]  cmd;
  logic [3:0]  cmd_op;
  logic [4:0]  pend;
  logic        wake_irq;
  logic        wake_light;
  logic        wake_deep;
  logic        light_block;
  logic        deep_block;
  logic [2:0]  top;
  logic [23:0] deep_wait;

  assign wr     = psel & penable & pwrite;
  assign rd     = psel & ~pwrite;
  assign cmd    = pwdata[SWIC_CMD_CODE_LSB +: 3];
  assign cmd_op = pwdata[SWIC_CMD_OP_LSB +: 4];
  // edge select 00 none, 01 rising, 10 falling, 11 both
  assign int_edge = (edge_sel[0] & int_s[1] & ~int_d)
                  | (edge_sel[1] & ~int_s[1] & int_d);
  assign pend   = source_request_flags & source_enable_flags;
  assign top    = swic_pick(pend);
  assign wake_irq = |pend;
  // timer1 forced wake ignores its enable, light standby only
  assign wake_light = (op[SWIC_OP_IRQ] & wake_irq)
                    | (op[SWIC_OP_TM1] & source_request_flags[SWIC_SRC_TM1])
                    | (op[SWIC_OP_RLS] & rls_low);
  // timer1 excluded from deep wake
  assign wake_deep = (op[SWIC_OP_IRQ]
                      & |(pend & ~(5'h1 << SWIC_SRC_TM1)))
                   | (op[SWIC_OP_RLS] & rls_low);
  assign light_block = (cmd_op[SWIC_OP_IRQ] & wake_irq)
                     | (cmd_op[SWIC_OP_TM1]
                        & source_request_flags[SWIC_SRC_TM1])
                     | (cmd_op[SWIC_OP_RLS] & rls_low);
  assign deep_block  = (cmd_op[SWIC_OP_IRQ] & wake_irq)
                     | (cmd_op[SWIC_OP_RLS] & rls_low);
  assign deep_wait = 24'(tm1_n) * 24'(11'h1 << (3 * tm1_m));

  always_comb begin
    next_req       = source_request_flags;
    next_en        = source_enable_flags;
    next_edge      = edge_sel;
    next_accept    = global_accept_flag;
    next_op        = op;
    next_tm1_n     = tm1_n;
    next_tm1_m     = tm1_m;
    next_wcnt      = wcnt;
    next_ret_addr  = ret_addr;
    next_ret_valid = 1'b0;
    next_state     = state;
    // taken interrupt clears its flag; new events win below
    if (irq_enter && global_accept_flag && wake_irq) begin
      next_req[top] = 1'b0;
    end
    if (wr && paddr == SWIC_REQ_OFF) begin
      next_req = source_request_flags & pwdata[4:0];
    end
    if (wr && paddr == SWIC_EN_OFF) begin
      next_en = pwdata[4:0];
    end
    if (wr && paddr == SWIC_EDGE_OFF) begin
      next_edge = pwdata[1:0];
    end
    if (wr && paddr == SWIC_TM1_OFF) begin
      next_tm1_n = pwdata[7:0];
      next_tm1_m = pwdata[9:8];
    end
    unique case (state)
      SWIC_RUN: begin
        if (wr && paddr == SWIC_CMD_OFF) begin
          if (cmd == SWIC_CMD_EI) begin
            next_accept = 1'b1;
          end else if (cmd == SWIC_CMD_DI) begin
            next_accept = 1'b0;
          end else if (cmd == SWIC_CMD_HALT && !light_block) begin
            next_op    = cmd_op;
            next_state = SWIC_HALT;
          end else if (cmd == SWIC_CMD_STOP && !deep_block) begin
            next_op    = cmd_op;
            // zero operand: only reset leaves
            next_state = (cmd_op == 4'h0) ? SWIC_DEAD : SWIC_STOP;
          end
        end
      end
      SWIC_HALT: begin
        if (wake_light) begin
          next_state     = SWIC_RUN;
          next_ret_valid = 1'b1;
          next_ret_addr  = 16'h0000; // continue
          if (pend != 5'h0 && global_accept_flag) begin
            next_ret_addr = SWIC_VEC_BASE - 16'(top);
          end
        end
      end
      SWIC_STOP: begin
        if (wake_deep) begin
          next_state    = SWIC_WAIT;
          next_wcnt     = deep_wait;
          next_ret_addr = 16'h0000;
          if (op[SWIC_OP_IRQ] && wake_irq && global_accept_flag) begin
            next_ret_addr = SWIC_VEC_BASE - 16'(top);
          end
        end
      end
      SWIC_WAIT: begin
        if (wcnt <= 24'h1) begin
          next_state     = SWIC_RUN;
          next_ret_valid = 1'b1;
        end else begin
          next_wcnt = wcnt - 24'h1;
        end
      end
      SWIC_DEAD: begin
        next_accept = 1'b0;
        next_req    = SWIC_REQ_RST;
        next_en     = 5'h0;
        next_edge   = 2'h0;
      end
      default: next_state = SWIC_RUN;
    endcase
    // hardware set wins over any clear
    if (int_edge) next_req[SWIC_SRC_PIN] = 1'b1;
    if (timer0_match) next_req[SWIC_SRC_TM0] = 1'b1;
    if (timer1_match && state != SWIC_STOP) begin
      next_req[SWIC_SRC_TM1] = 1'b1;
    end
    if (interval_timer_ovf && state != SWIC_STOP) begin
      next_req[SWIC_SRC_ITM] = 1'b1;
    end
    if (serial_done) next_req[SWIC_SRC_SIO] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_request_flags <= SWIC_REQ_RST;
      source_enable_flags  <= 5'h0;
      edge_sel             <= 2'h0;
      global_accept_flag   <= 1'b0;
      op                   <= 4'h0;
      tm1_n                <= SWIC_TM1N_RST;
      tm1_m                <= SWIC_TM1M_RST;
      wcnt                 <= RST_WAIT;
      ret_addr             <= SWIC_VEC_RESET;
      ret_valid            <= 1'b0;
      state                <= SWIC_WAIT;
    end else begin
      source_request_flags <= next_req;
      source_enable_flags  <= next_en;
      edge_sel             <= next_edge;
      global_accept_flag   <= next_accept;
      op                   <= next_op;
      tm1_n                <= next_tm1_n;
      tm1_m                <= next_tm1_m;
      wcnt                 <= next_wcnt;
      ret_addr             <= next_ret_addr;
      ret_valid            <= next_ret_valid;
      state                <= next_state;
    end
  end

  // read path registered; accept flag deliberately not readable
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = prdata;
    if (rd && !penable) begin
      unique case (paddr)
        SWIC_REQ_OFF:  next_prdata = {27'h0, source_request_flags};
        SWIC_EN_OFF:   next_prdata = {27'h0, source_enable_flags};
        SWIC_EDGE_OFF: next_prdata = {30'h0, edge_sel};
        SWIC_STAT_OFF: next_prdata = {25'h0, state, op};
        SWIC_TM1_OFF:  next_prdata = {22'h0, tm1_m, tm1_n};
        default:       next_prdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else begin
      prdata <= next_prdata;
    end
  end
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  logic deep;
  assign deep = (state == SWIC_STOP) || (state == SWIC_DEAD);
  assign cpu_clk_gate        = (state != SWIC_RUN);
  assign cpu_run             = (state == SWIC_RUN);
  assign osc_stop            = deep;
  assign timer0_hold         = deep & ~timer0_pin_clock;
  assign timer1_clear        = deep;
  assign interval_timer_hold = deep;
  assign serial_hold         = deep & ~serial_ext_clock;
  assign converter_clear     = deep;
  assign pins_force_input    = (state == SWIC_DEAD);
  assign soft_reset          = (state == SWIC_DEAD);
  assign restart_valid       = ret_valid;
  assign restart_addr        = ret_addr;
  assign irq_take   = global_accept_flag & wake_irq & cpu_run;
  assign irq_vector = SWIC_VEC_BASE - 16'(top);
endmodule

// ---- hw/swic_pkg.sv ----
// Purpose: constants for the standby, wake and interrupt controller
// Assumes: 32-bit APB, word-aligned registers
// Notes:   offsets are byte addresses
package swic_pkg;
  localparam int          SWIC_NSRC       = 5;
  // source index: 0 pin, 1 timer0, 2 timer1, 3 interval, 4 serial
  localparam int          SWIC_SRC_PIN    = 0;
  localparam int          SWIC_SRC_TM0    = 1;
  localparam int          SWIC_SRC_TM1    = 2;
  localparam int          SWIC_SRC_ITM    = 3;
  localparam int          SWIC_SRC_SIO    = 4;
  // register offsets
  localparam logic [11:0] SWIC_REQ_OFF    = 12'h000;
  localparam logic [11:0] SWIC_EN_OFF     = 12'h004;
  localparam logic [11:0] SWIC_EDGE_OFF   = 12'h008;
  localparam logic [11:0] SWIC_CMD_OFF    = 12'h00c;
  localparam logic [11:0] SWIC_STAT_OFF   = 12'h010;
  localparam logic [11:0] SWIC_TM1_OFF    = 12'h014;
  localparam logic [11:0] SWIC_ACK_OFF    = 12'h018;
  // command register fields
  localparam int          SWIC_CMD_OP_LSB = 0;
  localparam int          SWIC_CMD_CODE_LSB = 4;
  localparam logic [2:0]  SWIC_CMD_EI     = 3'h1;
  localparam logic [2:0]  SWIC_CMD_DI     = 3'h2;
  localparam logic [2:0]  SWIC_CMD_HALT   = 3'h3;
  localparam logic [2:0]  SWIC_CMD_STOP   = 3'h4;
  // operand bits
  localparam int          SWIC_OP_IRQ     = 3;
  localparam int          SWIC_OP_TM1     = 1;
  localparam int          SWIC_OP_RLS     = 0;
  // reset values
  localparam logic [4:0]  SWIC_REQ_RST    = 5'h0c;
  localparam logic [7:0]  SWIC_TM1N_RST   = 8'hff;
  localparam logic [1:0]  SWIC_TM1M_RST   = 2'h1;
  // post-reset wait: 256 ticks of clock/128
  localparam int          SWIC_RST_TICKS  = 256;
  localparam int          SWIC_RST_DIV    = 128;
  localparam logic [15:0] SWIC_VEC_BASE   = 16'h0005;
  localparam logic [15:0] SWIC_VEC_RESET  = 16'h0000;
  typedef enum logic [2:0] {
    SWIC_RUN   = 3'b000,
    SWIC_HALT  = 3'b001,
    SWIC_STOP  = 3'b010,
    SWIC_WAIT  = 3'b011,
    SWIC_DEAD  = 3'b100
  } swic_state_e;
endpackage

// ---- verif/swic_assertions.sv ----
// Purpose: port-level checks of the standby and interrupt controller
// Assumes: one clock domain, async active-low reset
// Notes:   peripheral controls are pure functions of the standby state and the timer0 and serial clock selects
`timescale 1ns/10ps
module swic_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        timer0_pin_clock,
  input wire logic        serial_ext_clock,
  input wire logic        cpu_clk_gate,
  input wire logic        osc_stop,
  input wire logic        timer0_hold,
  input wire logic        timer1_clear,
  input wire logic        interval_timer_hold,
  input wire logic        serial_hold,
  input wire logic        converter_clear,
  input wire logic        pins_force_input,
  input wire logic        soft_reset,
  input wire logic        cpu_run,
  input wire logic        restart_valid,
  input wire logic        irq_take,
  input wire logic [15:0] irq_vector
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_run_clock: assert property (cpu_run |-> !cpu_clk_gate)
    else $error("cpu clock gated while running");
  a_deep_group: assert property (osc_stop |-> cpu_clk_gate &&
    timer1_clear && interval_timer_hold && converter_clear)
    else $error("deep standby controls incomplete");
  a_t0_hold: assert property (timer0_hold == (osc_stop &&
    !timer0_pin_clock)) else $error("timer0 hold wrong");
  a_sio_hold: assert property (serial_hold == (osc_stop &&
    !serial_ext_clock)) else $error("serial hold wrong");
  a_dead_pins: assert property (pins_force_input |-> soft_reset && osc_stop)
    else $error("forced input without reinit");
  a_dead_stays: assert property (soft_reset |=> soft_reset)
    else $error("zero operand deep standby left without reset");
  a_vec_range: assert property (irq_take |-> cpu_run &&
    irq_vector inside {[16'h0001:16'h0005]}) else $error("bad vector");
  a_restart_pulse: assert property (restart_valid |=> !restart_valid)
    else $error("restart pulse too long");
  a_stop_no_exit: assert property (osc_stop |-> !restart_valid)
    else $error("restart while oscillator stopped");
  c_deep: cover property (osc_stop ##1 !osc_stop);
  c_take: cover property (irq_take);
  c_restart: cover property (restart_valid ##1 cpu_run);
endmodule

bind swic_ctrl swic_assertions swic_assertions_i (.pclk, .presetn,
  .timer0_pin_clock, .serial_ext_clock, .cpu_clk_gate, .osc_stop,
  .timer0_hold, .timer1_clear, .interval_timer_hold, .serial_hold,
  .converter_clear, .pins_force_input, .soft_reset, .cpu_run,
  .restart_valid, .irq_take, .irq_vector);

// ---- verif/swic_cpu_model.sv ----
// Purpose: cpu core and on-chip interrupt sources beside the controller
// Assumes: bench raises fire bits for one cycle
// Notes:   fire bits are timer0, timer1, interval, serial
`timescale 1ns/10ps
module swic_cpu_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] fire,
  input  wire logic       ack_en,
  input  wire logic       irq_take,
  output logic            timer0_match,
  output logic            timer1_match,
  output logic            interval_timer_ovf,
  output logic            serial_done,
  output logic            irq_enter
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {serial_done, interval_timer_ovf, timer1_match, timer0_match} <= '0;
      irq_enter <= 1'b0;
    end else begin
      {serial_done, interval_timer_ovf, timer1_match, timer0_match} <= fire;
      // one entry per take, so no flag is cleared twice
      irq_enter <= ack_en && irq_take && !irq_enter;
    end
  end
endmodule

// ---- verif/standby_wake_interrupt_ctrl_tb.sv ----
// Purpose: self-checking bench of the standby and interrupt controller
// Assumes: short reset wait of 4 ticks of clock/2
// Notes:   apb master waits on pready, never a fixed count
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  err_count++; $display("ERROR at %0t got %h expected %h", $time, \
  (g), (e)); end end
module standby_wake_interrupt_ctrl_tb;
  import swic_pkg::*;
  localparam int RT = 4;
  localparam int RD = 2;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic [3:0] fire = '0;
  logic [15:0] restart_addr, irq_vector;
  logic ack_en = 0, ext_int_pin = 0, standby_release_pin_n = 1;
  logic timer0_pin_clock = 0, serial_ext_clock = 0;
  logic pready, pslverr, timer0_match, timer1_match, interval_timer_ovf;
  logic serial_done, irq_enter, cpu_clk_gate, osc_stop, timer0_hold;
  logic timer1_clear, interval_timer_hold, serial_hold, converter_clear;
  logic pins_force_input, soft_reset, cpu_run, restart_valid, irq_take;
  int err_count = 0, n_compared = 0;
  always #20 pclk = ~pclk;
  swic_ctrl #(.RST_TICKS(RT), .RST_DIV(RD)) swic_ctrl_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_int_pin, .standby_release_pin_n, .timer0_match, .timer1_match,
    .interval_timer_ovf, .serial_done, .timer0_pin_clock,
    .serial_ext_clock, .irq_enter, .cpu_clk_gate, .osc_stop, .timer0_hold,
    .timer1_clear, .interval_timer_hold, .serial_hold, .converter_clear,
    .pins_force_input, .soft_reset, .cpu_run, .restart_valid,
    .restart_addr, .irq_take, .irq_vector);
  swic_cpu_model swic_cpu_model_i (.pclk, .presetn, .fire, .ack_en,
    .irq_take, .timer0_match, .timer1_match, .interval_timer_ovf,
    .serial_done, .irq_enter);
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  function automatic logic [31:0] cmd(logic [2:0] code, logic [3:0] op);
    return {25'h0, code, op};
  endfunction
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task pulse(input logic [3:0] f);
    @(posedge pclk) fire <= f;
    @(posedge pclk) fire <= '0;
    tick(2);
  endtask
  task wait_rv(output int c);
    c = 0;
    while (restart_valid !== 1'b1 && c < 80) begin @(posedge pclk); c++; end
    `CHK(c < 80, 1'b1)
  endtask
  task t_reset;
    int c;
    tick(1);
    `CHK(cpu_run, 1'b0)
    wait_rv(c);
    `CHK(c + 1 >= RT * RD, 1'b1)
    `CHK(restart_addr, SWIC_VEC_RESET)
    tick(2);
    apb(1'b0, SWIC_REQ_OFF, 32'h0);
    `CHK(rdat[4:0], SWIC_REQ_RST)
    apb(1'b0, SWIC_ACK_OFF, 32'h0);
    `CHK(rdat, 32'h0)
    `CHK(pslverr, 1'b0)
    $display("reset test done");
  endtask
  task t_irq;
    wr(SWIC_REQ_OFF, 32'h0);
    wr(SWIC_EN_OFF, 32'h3);
    pulse(4'h1);
    `CHK(irq_take, 1'b0)
    wr(SWIC_CMD_OFF, cmd(SWIC_CMD_EI, 4'h0));
    tick(1);
    `CHK(irq_vector, 16'h0004)
    wr(SWIC_EDGE_OFF, 32'h1);
    @(posedge pclk) ext_int_pin <= 1'b1;
    tick(5);
    `CHK(irq_vector, 16'h0005)
    wr(SWIC_CMD_OFF, cmd(SWIC_CMD_DI, 4'h0));
    tick(1);
    `CHK(irq_take, 1'b0)
    wr(SWIC_CMD_OFF, cmd(SWIC_CMD_EI, 4'h0));
    ack_en <= 1'b1;
    tick(8);
    apb(1'b0, SWIC_REQ_OFF, 32'h0);
    `CHK(rdat[1:0], 2'b00)
    ack_en <= 1'b0;
    @(posedge pclk) ext_int_pin <= 1'b0;
    $display("interrupt test done");
  endtask
  task t_halt;
    int c;
    wr(SWIC_REQ_OFF, 32'h0);
    pulse(4'h2);
    wr(SWIC_EN_OFF, 32'h2);
    wr(SWIC_CMD_OFF, cmd(SWIC_CMD_HALT, 4'h8));
    tick(1);
    `CHK(cpu_clk_gate, 1'b1)
    `CHK(osc_stop, 1'b0)
    pulse(4'h1);
    wait_rv(c);
    `CHK(restart_addr, 16'h0004)
    tick(2);
    wr(SWIC_CMD_OFF, cmd(SWIC_CMD_HALT, 4'h8));
    tick(1);
    `CHK(cpu_clk_gate, 1'b0)
    wr(SWIC_CMD_OFF, cmd(SWIC_CMD_DI, 4'h0));
    wr(SWIC_REQ_OFF, 32'h0);
    wr(SWIC_EN_OFF, 32'h0);
    wr(SWIC_CMD_OFF, cmd(SWIC_CMD_HALT, 4'h2));
    pulse(4'h2);
    wait_rv(c);
    `CHK(restart_addr, 16'h0000)
    tick(2);
    wr(SWIC_CMD_OFF, cmd(SWIC_CMD_HALT, 4'h1));
    @(posedge pclk) standby_release_pin_n <= 1'b0;
    wait_rv(c);
    `CHK(restart_addr, 16'h0000)
    @(posedge pclk) standby_release_pin_n <= 1'b1;
    tick(2);
    $display("light standby test done");
  endtask
  task t_stop;
    int c;
    wr(SWIC_REQ_OFF, 32'h0);
    wr(SWIC_EN_OFF, 32'h4);
    wr(SWIC_TM1_OFF, 32'd20);
    tick(1);
    wr(SWIC_CMD_OFF, cmd(SWIC_CMD_STOP, 4'h9));
    tick(1);
    `CHK(osc_stop, 1'b1)
    `CHK(converter_clear, 1'b1)
    `CHK(timer0_hold, 1'b1)
    `CHK(serial_hold, 1'b1)
    `CHK(timer1_clear, 1'b1)
    `CHK(interval_timer_hold, 1'b1)
    timer0_pin_clock <= 1'b1;
    serial_ext_clock <= 1'b1;
    tick(1);
    `CHK(timer0_hold, 1'b0)
    `CHK(serial_hold, 1'b0)
    pulse(4'h2);
    tick(3);
    `CHK(osc_stop, 1'b1)
    @(posedge pclk) standby_release_pin_n <= 1'b0;
    wait_rv(c);
    `CHK(c >= 20, 1'b1)
    `CHK(restart_addr, 16'h0000)
    @(posedge pclk) standby_release_pin_n <= 1'b1;
    timer0_pin_clock <= 1'b0;
    serial_ext_clock <= 1'b0;
    tick(2);
    $display("deep standby test done");
  endtask
  task t_zero;
    wr(SWIC_CMD_OFF, cmd(SWIC_CMD_HALT, 4'h0));
    @(posedge pclk) standby_release_pin_n <= 1'b0;
    pulse(4'h2);
    tick(6);
    `CHK(cpu_clk_gate, 1'b1)
    @(posedge pclk) presetn <= 1'b0;
    standby_release_pin_n <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    wr(SWIC_CMD_OFF, cmd(SWIC_CMD_STOP, 4'h0));
    tick(1);
    `CHK(pins_force_input, 1'b1)
    @(posedge pclk) standby_release_pin_n <= 1'b0;
    tick(10);
    `CHK(soft_reset, 1'b1)
    @(posedge pclk) presetn <= 1'b0;
    standby_release_pin_n <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    $display("zero operand test done");
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_irq();
    t_halt();
    t_stop();
    t_zero();
    give_verdict();
  end
endmodule
